// file: hw/vups_csum.sv
// Ones-complement accumulator for the IP header checksum
`default_nettype none
module vups_csum (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic add,
  input wire logic [15:0] word,
  output logic [15:0] csum
);
  logic [15:0] acc_q;
  logic [16:0] sum;

  ////////////////////////////////////////////////////////////////////////
  // End-around carry folds back in one step; it cannot carry twice
  assign sum = {1'b0, acc_q} + {1'b0, word};
  assign csum = ~acc_q;

  // Accumulator
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q <= '0;
    end else if (clk_en) begin
      if (clear) begin
        acc_q <= '0;
      end else if (add) begin
        acc_q <= sum[15:0] + {15'h0000, sum[16]};
      end
    end
  end
endmodule : vups_csum
`default_nettype wire

// file: hw/vups_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module vups_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Full when pointers differ only in the wrap bit
  assign level = wr_q - rd_q;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : vups_fifo
`default_nettype wire

// file: hw/vups_top.sv
// Video strip to UDP packet sender toward an Ethernet controller
// Notes on behaviour
// - One block clock; I/O timing counted in cycles
// - Controller and SRAM word reads take two cycles
// - Controller writes and SRAM writes take one cycle
// - Buffer loading alone never starts a send
// - Write 0x22 to command after loading
// - Then start remote DMA write to FIFO
// - Finally write 0x26 to start transmit
// - IP version 4, header length 5
// - TOS zero, total length 537
// - Flags 010, fragment offset zero
// - TTL all ones, protocol 17
// - New identification and checksum every packet
// - Fixed source and destination IP addresses
// - UDP ports 5001, UDP length 517
// - UDP checksum fixed at zero
// - 32 strips, position byte 0 to 31
// - IP, UDP, position byte, 512 pixels
// - MAC destination, source, type precede payload
// - Image 128x128, one byte per pixel
// - Drain decoder words into SRAM promptly
// - Controller accesses 16 bits, SRAM 32
// - Registers below 0x4000, buffer from 0x4000
`default_nettype none
module vups_top #(
  parameter logic [47:0] DST_MAC = 48'hffff_ffff_ffff,
  parameter logic [47:0] SRC_MAC = 48'h0200_0000_0001,
  parameter logic [31:0] SRC_IP = 32'h0a00_0001,
  parameter logic [31:0] DST_IP = 32'h0a00_0002,
  parameter int FIFO_DEPTH = vups_pkg::BUF_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic vid_valid,
  input wire logic [31:0] vid_data,
  output logic vid_ready,
  output logic [11:0] sram_addr,
  output logic [31:0] sram_wdata,
  output logic sram_we,
  output logic sram_re,
  input wire logic [31:0] sram_rdata,
  output logic [14:0] eth_addr,
  output logic [15:0] eth_wdata,
  output logic eth_wr,
  output logic eth_rd,
  input wire logic [15:0] eth_rdata,
  output logic [4:0] strip_pos,
  output logic busy
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  vups_pkg::vups_state_e state_q;
  vups_pkg::vups_state_e state_d;
  logic [8:0] idx_q;
  logic [8:0] idx_d;
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic [7:0] carry_q;
  logic [7:0] carry_d;
  logic [31:0] pix_q;
  logic [31:0] pix_d;
  logic [14:0] buf_q;
  logic [14:0] buf_d;
  logic [15:0] id_q;
  logic [4:0] strip_q;
  logic [5:0] avail_q;
  logic [11:0] wr_ptr_q;
  logic take_strip;
  logic pkt_done;
  logic [14:0] eth_addr_d;
  logic [15:0] eth_wdata_d;
  logic eth_wr_d;
  logic eth_rd_d;
  logic sram_re_d;
  logic cs_clr;
  logic cs_add;
  logic [15:0] cs_word;
  logic [15:0] cs_val;
  logic [22:0] step;
  logic [31:0] f_data;
  logic f_valid;
  logic f_in_ready;
  logic [LW-1:0] f_level;
  logic push;
  logic pop;
  logic strip_end;

  ////////////////////////////////////////////////////////////////////////
  // Header word in network order, indexed from the MAC destination
  function automatic logic [15:0] hdr_word(input logic [4:0] i,
                                           input logic [15:0] id,
                                           input logic [15:0] cs);
    case (i)
      5'h00: hdr_word = DST_MAC[47:32];
      5'h01: hdr_word = DST_MAC[31:16];
      5'h02: hdr_word = DST_MAC[15:0];
      5'h03: hdr_word = SRC_MAC[47:32];
      5'h04: hdr_word = SRC_MAC[31:16];
      5'h05: hdr_word = SRC_MAC[15:0];
      5'h06: hdr_word = vups_pkg::ETYPE_IPV4;
      5'h07: hdr_word = {vups_pkg::IP_VER, vups_pkg::IP_IHL,
                         vups_pkg::IP_TOS};
      5'h08: hdr_word = vups_pkg::IP_TOT_LEN;
      5'h09: hdr_word = id;
      5'h0a: hdr_word = {vups_pkg::IP_FLAGS, vups_pkg::IP_FRAG};
      5'h0b: hdr_word = {vups_pkg::IP_TTL, vups_pkg::IP_PROTO_UDP};
      5'h0c: hdr_word = cs;
      5'h0d: hdr_word = SRC_IP[31:16];
      5'h0e: hdr_word = SRC_IP[15:0];
      5'h0f: hdr_word = DST_IP[31:16];
      5'h10: hdr_word = DST_IP[15:0];
      5'h11: hdr_word = vups_pkg::UDP_PORT;
      5'h12: hdr_word = vups_pkg::UDP_PORT;
      5'h13: hdr_word = vups_pkg::UDP_LEN;
      5'h14: hdr_word = vups_pkg::UDP_CSUM;
      default: hdr_word = 16'h0000;
    endcase
  endfunction : hdr_word

  // First network byte travels on the low data lane
  function automatic logic [15:0] lane(input logic [15:0] w);
    lane = {w[7:0], w[15:8]};
  endfunction : lane

  // Controller register program after the buffer is loaded
  function automatic logic [22:0] cmd_step(input logic [3:0] s);
    case (s)
      4'h0: cmd_step = {vups_pkg::REG_CMD, vups_pkg::CMD_ACTIVATE};
      4'h1: cmd_step = {vups_pkg::REG_RDMA_ADR_LO, vups_pkg::ZERO_BYTE};
      4'h2: cmd_step = {vups_pkg::REG_RDMA_ADR_HI, vups_pkg::BUF_PAGE};
      4'h3: cmd_step = {vups_pkg::REG_RDMA_CNT_LO,
                        vups_pkg::FRAME_BYTES[7:0]};
      4'h4: cmd_step = {vups_pkg::REG_RDMA_CNT_HI,
                        vups_pkg::FRAME_BYTES[15:8]};
      4'h5: cmd_step = {vups_pkg::REG_CMD, vups_pkg::CMD_RDMA_WRITE};
      4'h6: cmd_step = {vups_pkg::REG_TX_PAGE, vups_pkg::BUF_PAGE};
      4'h7: cmd_step = {vups_pkg::REG_TX_CNT_LO,
                        vups_pkg::FRAME_BYTES[7:0]};
      4'h8: cmd_step = {vups_pkg::REG_TX_CNT_HI,
                        vups_pkg::FRAME_BYTES[15:8]};
      4'h9: cmd_step = {vups_pkg::REG_CMD, vups_pkg::CMD_TRANSMIT};
      default: cmd_step = {vups_pkg::REG_CMD, vups_pkg::CMD_ACTIVATE};
    endcase
  endfunction : cmd_step

  ////////////////////////////////////////////////////////////////////////
  // Video intake buffer between decoder and SRAM
  vups_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(vid_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data),
    .level(f_level)
  );

  // IP header checksum accumulator
  vups_csum u_csum (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .clear(cs_clr),
    .add(cs_add),
    .word(cs_word),
    .csum(cs_val)
  );

  // SRAM is single ported: writes win, reads only on an empty buffer
  assign push = vid_valid && vid_ready && f_in_ready;
  assign pop = f_valid && (state_q != vups_pkg::ST_RD_WAIT);
  assign strip_end = pop && (&wr_ptr_q[6:0]);
  assign step = cmd_step(idx_q[3:0]);

  ////////////////////////////////////////////////////////////////////////
  // Packet sequencer
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    wait_d = wait_q;
    carry_d = carry_q;
    pix_d = pix_q;
    buf_d = buf_q;
    eth_addr_d = eth_addr;
    eth_wdata_d = eth_wdata;
    eth_wr_d = 1'b0;
    eth_rd_d = 1'b0;
    sram_re_d = 1'b0;
    cs_clr = 1'b0;
    cs_add = 1'b0;
    cs_word = 16'h0000;
    take_strip = 1'b0;
    pkt_done = 1'b0;
    case (state_q)
      vups_pkg::ST_IDLE: begin
        if (avail_q != 6'h00) begin
          take_strip = 1'b1;
          state_d = vups_pkg::ST_POLL;
        end
      end
      vups_pkg::ST_POLL: begin
        eth_rd_d = 1'b1;
        eth_addr_d = vups_pkg::REG_CMD;
        wait_d = vups_pkg::ETH_RD_CYC;
        state_d = vups_pkg::ST_POLL_WAIT;
      end
      vups_pkg::ST_POLL_WAIT: begin
        if (wait_q == 2'h1) begin
          // Busy transmitter: our buffer area is still in use
          if (eth_rdata[vups_pkg::TX_BIT]) begin
            state_d = vups_pkg::ST_POLL;
          end else begin
            cs_clr = 1'b1;
            idx_d = {4'h0, vups_pkg::CSUM_FIRST};
            state_d = vups_pkg::ST_CSUM;
          end
        end else begin
          wait_d = wait_q - 2'h1;
        end
      end
      vups_pkg::ST_CSUM: begin
        cs_add = 1'b1;
        cs_word = hdr_word(idx_q[4:0], id_q, 16'h0000);
        if (idx_q[4:0] == vups_pkg::CSUM_LAST) begin
          idx_d = '0;
          buf_d = vups_pkg::BUF_BASE;
          state_d = vups_pkg::ST_HDR;
        end else begin
          idx_d = idx_q + 9'h001;
        end
      end
      vups_pkg::ST_HDR: begin
        eth_wr_d = 1'b1;
        eth_addr_d = buf_q;
        eth_wdata_d = lane(hdr_word(idx_q[4:0], id_q, cs_val));
        buf_d = buf_q + 15'h0002;
        if (idx_q == 9'(vups_pkg::HDR_WORDS - 1)) begin
          idx_d = '0;
          carry_d = {3'h0, strip_q};
          state_d = vups_pkg::ST_RD;
        end else begin
          idx_d = idx_q + 9'h001;
        end
      end
      vups_pkg::ST_RD: begin
        if (!f_valid) begin
          sram_re_d = 1'b1;
          wait_d = vups_pkg::SRAM_RD_CYC;
          state_d = vups_pkg::ST_RD_WAIT;
        end
      end
      vups_pkg::ST_RD_WAIT: begin
        if (wait_q == 2'h1) begin
          pix_d = sram_rdata;
          state_d = vups_pkg::ST_PIX0;
        end else begin
          wait_d = wait_q - 2'h1;
        end
      end
      vups_pkg::ST_PIX0: begin
        // Odd offset of the pixels: carry byte pairs with pixel 0
        eth_wr_d = 1'b1;
        eth_addr_d = buf_q;
        eth_wdata_d = lane({carry_q, pix_q[7:0]});
        buf_d = buf_q + 15'h0002;
        state_d = vups_pkg::ST_PIX1;
      end
      vups_pkg::ST_PIX1: begin
        eth_wr_d = 1'b1;
        eth_addr_d = buf_q;
        // Pixel 1 is the earlier byte, so it leads in network order
        eth_wdata_d = lane({pix_q[15:8], pix_q[23:16]});
        buf_d = buf_q + 15'h0002;
        carry_d = pix_q[31:24];
        if (idx_q == 9'(vups_pkg::STRIP_WORDS - 1)) begin
          state_d = vups_pkg::ST_TAIL;
        end else begin
          idx_d = idx_q + 9'h001;
          state_d = vups_pkg::ST_RD;
        end
      end
      vups_pkg::ST_TAIL: begin
        eth_wr_d = 1'b1;
        eth_addr_d = buf_q;
        eth_wdata_d = lane({carry_q, vups_pkg::ZERO_BYTE});
        idx_d = '0;
        state_d = vups_pkg::ST_CMD;
      end
      vups_pkg::ST_CMD: begin
        eth_wr_d = 1'b1;
        eth_addr_d = step[22:8];
        eth_wdata_d = {vups_pkg::ZERO_BYTE, step[7:0]};
        if (idx_q[3:0] == vups_pkg::CMD_STEPS - 4'h1) begin
          pkt_done = 1'b1;
          idx_d = '0;
          state_d = vups_pkg::ST_IDLE;
        end else begin
          idx_d = idx_q + 9'h001;
        end
      end
      default: begin
        state_d = vups_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= vups_pkg::ST_IDLE;
      idx_q <= '0;
      wait_q <= '0;
      carry_q <= '0;
      pix_q <= '0;
      buf_q <= vups_pkg::BUF_BASE;
    end else if (clk_en) begin
      state_q <= state_d;
      idx_q <= idx_d;
      wait_q <= wait_d;
      carry_q <= carry_d;
      pix_q <= pix_d;
      buf_q <= buf_d;
    end
  end

  // Controller port, one strobe cycle per access
  always_ff @(posedge clock) begin
    if (reset) begin
      eth_addr <= vups_pkg::REG_CMD;
      eth_wdata <= '0;
      eth_wr <= 1'b0;
      eth_rd <= 1'b0;
    end else if (clk_en) begin
      eth_addr <= eth_addr_d;
      eth_wdata <= eth_wdata_d;
      eth_wr <= eth_wr_d;
      eth_rd <= eth_rd_d;
    end
  end

  // SRAM port: image stored as packed bytes, pixel 0 in the low lane
  always_ff @(posedge clock) begin
    if (reset) begin
      sram_addr <= '0;
      sram_wdata <= '0;
      sram_we <= 1'b0;
      sram_re <= 1'b0;
    end else if (clk_en) begin
      sram_we <= pop;
      sram_re <= sram_re_d;
      if (pop) begin
        sram_addr <= wr_ptr_q;
        sram_wdata <= f_data;
      end else if (sram_re_d) begin
        sram_addr <= {strip_q, idx_q[6:0]};
      end
    end
  end

  // Ready is registered, so stop one word early to absorb the lag
  always_ff @(posedge clock) begin
    if (reset) begin
      vid_ready <= 1'b0;
    end else if (clk_en) begin
      vid_ready <= ({1'b0, f_level} + {{LW{1'b0}}, push})
                   < (LW + 1)'(FIFO_DEPTH - 1);
    end
  end

  // Strip bookkeeping: a strip is sendable once fully written
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_q <= '0;
      avail_q <= '0;
    end else if (clk_en) begin
      if (pop) begin
        wr_ptr_q <= wr_ptr_q + 12'h001;
      end
      // Writer lapping the sender just saturates the backlog
      if (strip_end && !take_strip &&
          avail_q != 6'(vups_pkg::STRIPS)) begin
        avail_q <= avail_q + 6'h01;
      end else if (take_strip && !strip_end) begin
        avail_q <= avail_q - 6'h01;
      end
    end
  end

  // Packet identity and position advance once transmit is commanded
  always_ff @(posedge clock) begin
    if (reset) begin
      id_q <= '0;
      strip_q <= '0;
      strip_pos <= '0;
      busy <= 1'b0;
    end else if (clk_en) begin
      if (pkt_done) begin
        id_q <= id_q + 16'h0001;
        strip_q <= strip_q + 5'h01;
      end
      strip_pos <= strip_q;
      busy <= (state_d != vups_pkg::ST_IDLE);
    end
  end
endmodule : vups_top
`default_nettype wire

// file: inc/vups_pkg.sv
// Shared constants for the video UDP packet sender
`default_nettype none
package vups_pkg;
  // Image and strip geometry
  localparam int IMG_W = 128;
  localparam int IMG_H = 128;
  localparam int STRIPS = 32;
  localparam int STRIP_ROWS = 4;
  localparam int STRIP_WORDS = IMG_W * STRIP_ROWS / 4;
  localparam int IMG_WORDS = IMG_W * IMG_H / 4;
  localparam int DEC_FIFO_WORDS = 32;
  localparam int BUF_DEPTH = 8;

  // Frame layout in 16-bit controller words, frame length in bytes
  localparam int HDR_WORDS = 21;
  localparam logic [4:0] CSUM_FIRST = 5'h07;
  localparam logic [4:0] CSUM_LAST = 5'h10;
  localparam logic [15:0] FRAME_BYTES = 16'h022b;

  // Header field values
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [3:0] IP_VER = 4'h4;
  localparam logic [3:0] IP_IHL = 4'h5;
  localparam logic [7:0] IP_TOS = 8'h00;
  localparam logic [15:0] IP_TOT_LEN = 16'h0219;
  localparam logic [2:0] IP_FLAGS = 3'h2;
  localparam logic [12:0] IP_FRAG = 13'h0000;
  localparam logic [7:0] IP_TTL = 8'hff;
  localparam logic [7:0] IP_PROTO_UDP = 8'h11;
  localparam logic [15:0] UDP_PORT = 16'h1389;
  localparam logic [15:0] UDP_LEN = 16'h0205;
  localparam logic [15:0] UDP_CSUM = 16'h0000;

  // Controller map and commands
  localparam logic [14:0] BUF_BASE = 15'h4000;
  localparam logic [14:0] REG_CMD = 15'h0000;
  localparam logic [14:0] REG_TX_PAGE = 15'h0004;
  localparam logic [14:0] REG_TX_CNT_LO = 15'h0005;
  localparam logic [14:0] REG_TX_CNT_HI = 15'h0006;
  localparam logic [14:0] REG_RDMA_ADR_LO = 15'h0008;
  localparam logic [14:0] REG_RDMA_ADR_HI = 15'h0009;
  localparam logic [14:0] REG_RDMA_CNT_LO = 15'h000a;
  localparam logic [14:0] REG_RDMA_CNT_HI = 15'h000b;
  localparam logic [7:0] CMD_ACTIVATE = 8'h22;
  localparam logic [7:0] CMD_RDMA_WRITE = 8'h12;
  localparam logic [7:0] CMD_TRANSMIT = 8'h26;
  localparam logic [7:0] BUF_PAGE = 8'h40;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int TX_BIT = 2;
  localparam logic [3:0] CMD_STEPS = 4'ha;

  // Access timing in cycles of the block clock
  localparam int CLK_MHZ = 25;
  localparam logic [1:0] SRAM_RD_CYC = 2'h2;
  localparam logic [1:0] ETH_RD_CYC = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_POLL_WAIT, ST_CSUM, ST_HDR,
    ST_RD, ST_RD_WAIT, ST_PIX0, ST_PIX1, ST_TAIL, ST_CMD
  } vups_state_e;
endpackage : vups_pkg
`default_nettype wire

// file: tb/tb_video_udp_packet_sender.sv
// Bench for the video UDP packet sender with SRAM and controller models
`default_nettype none
module tb_video_udp_packet_sender;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] DMAC = 48'h0200_0000_00aa;
  localparam logic [47:0] SMAC = 48'h0200_0000_0055;
  localparam logic [31:0] SIP = 32'hc0a8_0107;
  localparam logic [31:0] DIP = 32'hc0a8_01f3;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic vid_valid = 1'b0;
  logic [31:0] vid_data = 32'h0000_0000;
  logic [31:0] sram_rdata = 32'h0000_0000;
  logic vid_ready, sram_we, sram_re, eth_wr, eth_rd, busy, viol;
  logic [11:0] sram_addr;
  logic [31:0] sram_wdata;
  logic [14:0] eth_addr;
  logic [15:0] eth_wdata, eth_rdata;
  logic [4:0] strip_pos;
  logic [31:0] mem [4096];
  logic [30:0] wq[$];
  int err_count = 0;
  int comparisons = 0;
  always #20 clock = ~clock;
  vups_top #(.DST_MAC(DMAC), .SRC_MAC(SMAC), .SRC_IP(SIP), .DST_IP(DIP),
    .FIFO_DEPTH(8)) dut (.clock(clock), .reset(reset), .clk_en(clk_en),
    .vid_valid(vid_valid), .vid_data(vid_data), .vid_ready(vid_ready),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_we(sram_we),
    .sram_re(sram_re), .sram_rdata(sram_rdata), .eth_addr(eth_addr),
    .eth_wdata(eth_wdata), .eth_wr(eth_wr), .eth_rd(eth_rd),
    .eth_rdata(eth_rdata), .strip_pos(strip_pos), .busy(busy));
  vups_eth_model #(.BUSY_CYC(40)) eth (.clock(clock), .reset(reset),
    .eth_addr(eth_addr), .eth_wdata(eth_wdata), .eth_wr(eth_wr),
    .eth_rd(eth_rd), .eth_rdata(eth_rdata), .viol(viol));
  //////////////////////////////////////////////////////////////////////////
  // SRAM answering on the edge after the strobe, and a write log
  always @(posedge clock) begin
    if (sram_we) mem[sram_addr] <= sram_wdata;
    if (eth_wr) wq.push_back({eth_addr, eth_wdata});
    if (sram_re) sram_rdata <= mem[sram_addr];
    else sram_rdata <= ~sram_rdata;
  end
  //////////////////////////////////////////////////////////////////////////
  // Pixel value; the strip term catches strips sent from the wrong place
  function automatic logic [7:0] pix(input int s, input int i);
    return 8'(i + 3 * s);
  endfunction : pix
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task timeout;
    err_count++;
    $display("ERROR t=%0t wait limit used up", $time);
    give_verdict();
  endtask : timeout
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // One strip of 128 words, back to back, honouring the ready level
  task feed(input int s);
    int w;
    int n;
    for (w = 0; w < 128; w++) begin
      vid_valid = 1'b1;
      vid_data = {pix(s, 4 * w + 3), pix(s, 4 * w + 2), pix(s, 4 * w + 1),
        pix(s, 4 * w)};
      n = 0;
      while (vid_ready !== 1'b1 && n < 2000) begin
        @(posedge clock);
        #1;
        n++;
      end
      if (n == 2000) timeout();
      @(posedge clock);
      #1;
    end
    vid_valid = 1'b0;
  endtask : feed
  // Whole packet for strip s: header, payload, then command writes
  task check_packet(input int s);
    logic [15:0] h[21];
    logic [23:0] r[10];
    logic [31:0] a;
    logic [30:0] e;
    logic [15:0] d;
    int j;
    int n;
    h = '{DMAC[47:32], DMAC[31:16], DMAC[15:0], SMAC[47:32], SMAC[31:16],
      SMAC[15:0], 16'h0800, 16'h4500, 16'h0219, 16'(s), 16'h4000, 16'hff11,
      16'h0000, SIP[31:16], SIP[15:0], DIP[31:16], DIP[15:0], 16'h1389,
      16'h1389, 16'h0205, 16'h0000};
    r = '{24'h00_0022, 24'h00_0800, 24'h00_0940, 24'h00_0a2b, 24'h00_0b02,
      24'h00_0012, 24'h00_0440, 24'h00_052b, 24'h00_0602, 24'h00_0026};
    a = 32'h0000_0000;
    for (j = 7; j < 17; j++) a = a + {16'h0000, h[j]};
    a = {16'h0000, a[15:0]} + {16'h0000, a[31:16]};
    a = {16'h0000, a[15:0]} + {16'h0000, a[31:16]};
    h[12] = ~a[15:0];
    n = 0;
    while (wq.size() < 288 && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 20000) timeout();
    cmp({27'h000_0000, strip_pos}, 32'((s + 1) % 32));
    cmp({31'h0000_0000, busy}, {31'h0000_0000, s < 32});
    for (j = 0; j < 21; j++) begin
      e = wq.pop_front();
      cmp({1'b0, e}, {1'b0, 15'h4000 + 15'(2 * j), h[j][7:0], h[j][15:8]});
    end
    for (j = 0; j < 257; j++) begin
      e = wq.pop_front();
      if (j == 0) d = {pix(s, 0), 8'(s % 32)};
      else if (j == 256) d = {8'h00, pix(s, 511)};
      else d = {pix(s, 2 * j), pix(s, 2 * j - 1)};
      cmp({1'b0, e}, {1'b0, 15'h402a + 15'(2 * j), d});
    end
    for (j = 0; j < 10; j++) begin
      e = wq.pop_front();
      cmp({9'h000, e[30:16], e[7:0]}, {8'h00, r[j]});
    end
  endtask : check_packet
  //////////////////////////////////////////////////////////////////////////
  // Strip s+1 streams in while packet s goes out; 33 strips wrap position
  initial begin
    int s;
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
    feed(0);
    for (s = 0; s < 33; s++) begin
      fork
        if (s < 32) feed(s + 1);
        check_packet(s);
      join
    end
    cmp({31'h0000_0000, viol}, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb_video_udp_packet_sender
bind vups_top vups_monitor #(.DST_MAC(DST_MAC)) mon (.clock(clock),
  .reset(reset), .eth_addr(eth_addr), .eth_wdata(eth_wdata),
  .eth_wr(eth_wr), .sram_re(sram_re), .sram_we(sram_we));
`default_nettype wire

// file: tb/vups_eth_model.sv
// Behavioural model of the Ethernet controller's command side
`default_nettype none
module vups_eth_model #(
  parameter int BUSY_CYC = 40
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [14:0] eth_addr,
  input wire logic [15:0] eth_wdata,
  input wire logic eth_wr,
  input wire logic eth_rd,
  output logic [15:0] eth_rdata,
  output logic viol
);
  logic [7:0] busy_q;
  // Transmit busy, raised by the start command, so polls see it slow
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_q <= 8'h00;
    end else if (eth_wr && eth_addr == 15'h0000
                 && eth_wdata[7:0] == 8'h26) begin
      busy_q <= 8'(BUSY_CYC);
    end else if (busy_q != 8'h00) begin
      busy_q <= busy_q - 8'h01;
    end
  end
  // Buffer writes while still sending would corrupt the frame
  always_ff @(posedge clock) begin
    if (reset) begin
      viol <= 1'b0;
    end else if (eth_wr && eth_addr[14] && busy_q != 8'h00) begin
      viol <= 1'b1;
    end
  end
  // Answer stands from the edge after the strobe to the sampling edge
  always_ff @(posedge clock) begin
    if (reset) begin
      eth_rdata <= 16'h5a5a;
    end else if (eth_rd) begin
      eth_rdata <= {13'h0000, busy_q != 8'h00, 2'h0};
    end else begin
      eth_rdata <= ~eth_rdata;
    end
  end
endmodule : vups_eth_model
`default_nettype wire

// file: tb/vups_monitor.sv
// Checker for the packet sender's controller and SRAM ports
`default_nettype none
module vups_monitor #(
  parameter logic [47:0] DST_MAC = 48'hffff_ffff_ffff
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [14:0] eth_addr,
  input wire logic [15:0] eth_wdata,
  input wire logic eth_wr,
  input wire logic sram_re,
  input wire logic sram_we
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic c22;
  logic c12;
  logic c26;
  // Command writes carry their code in the low lane
  assign c22 = eth_wr && eth_addr == 15'h0000 && eth_wdata[7:0] == 8'h22;
  assign c12 = eth_wr && eth_addr == 15'h0000 && eth_wdata[7:0] == 8'h12;
  assign c26 = eth_wr && eth_addr == 15'h0000 && eth_wdata[7:0] == 8'h26;
  //////////////////////////////////////////////////////////////////////////
  // Register writes run back to back, so the spacing is exact
  a_cmd_activate: assert property (c22 |-> ##5 c12)
    else $error("remote copy start missing after activate");
  a_cmd_transmit: assert property (c12 |-> ##4 c26)
    else $error("transmit command missing after remote copy");
  a_rd_spacing: assert property (sram_re |=> !sram_re [*2])
    else $error("SRAM reads too close");
  a_rd_quiet: assert property (sram_re |=> !sram_we [*2])
    else $error("SRAM write during read wait");
  a_mac_first: assert property (eth_wr && eth_addr == 15'h4000 |->
    eth_wdata == {DST_MAC[39:32], DST_MAC[47:40]})
    else $error("first header word wrong");
  a_ip_start: assert property (eth_wr && eth_addr == 15'h400e |->
    eth_wdata == 16'h0045 ##1 eth_wr && eth_wdata == 16'h1902)
    else $error("IP version or length wrong");
  a_flags_ttl: assert property (eth_wr && eth_addr == 15'h4014 |->
    eth_wdata == 16'h0040 ##1 eth_wr && eth_wdata == 16'h11ff)
    else $error("IP flags or lifetime wrong");
  a_udp_hdr: assert property (eth_wr && eth_addr == 15'h4022 |->
    eth_wdata == 16'h8913 ##1 eth_wr && eth_wdata == 16'h8913
    ##1 eth_wr && eth_wdata == 16'h0502 ##1 eth_wr && eth_wdata == 16'h0000)
    else $error("UDP header wrong");
  // Next load needs a poll and the checksum pass first
  a_buf_hold: assert property (c26 |=> !(eth_wr && eth_addr[14]) [*8])
    else $error("buffer written right after transmit start");
endmodule : vups_monitor
`default_nettype wire
